/* scw_pkg.sv */
// Constants, carriers and register map of the sleep clock and wake control block.
// Assumes a single 125 MHz core clock and a synchronous active-high reset.
package scw_pkg;

    localparam int SCW_ADDR_W = 12;

    // Register indices; byte address is four times the index
    localparam logic [31:0] IDX_GATE_LO = 32'h4000100c;
    localparam logic [31:0] IDX_GATE_HI = 32'h4000100d;
    localparam logic [31:0] IDX_WAKE_CFG = 32'h4000100e;
    localparam logic [31:0] IDX_PWR_CTRL = 32'h4000100f;
    localparam logic [31:0] IDX_WAKE_STAT = 32'h40001010;
    localparam logic [31:0] IDX_PWR_PLAN = 32'h40001020;
    localparam logic [31:0] IDX_AUX_TRIM = 32'h40001022;
    localparam logic [31:0] IDX_BAT_CTRL = 32'h40001024;
    localparam logic [31:0] IDX_BAT_CFG = 32'h40001025;
    localparam logic [31:0] IDX_BAT_STATE = 32'h40001026;

    localparam logic [7:0] GATE_LO_RESET = 8'h00;
    localparam logic [7:0] GATE_HI_RESET = 8'h00;
    localparam logic [7:0] GATE_HI_WMASK = 8'h95;
    localparam logic [7:0] WAKE_CFG_RESET = 8'h20;
    localparam logic [7:0] WAKE_CFG_WMASK = 8'hf9;
    localparam logic [7:0] PWR_CTRL_RESET = 8'h00;
    localparam logic [7:0] PWR_CTRL_WMASK = 8'h70;
    localparam logic [7:0] PWR_CTRL_RMASK = 8'h30;
    localparam logic [15:0] PWR_PLAN_RESET = 16'h11df;
    localparam logic [15:0] PWR_PLAN_WMASK = 16'hffdf;
    localparam logic [15:0] AUX_TRIM_RESET = 16'h0022;
    localparam logic [15:0] AUX_TRIM_WMASK = 16'h003f;
    localparam logic [7:0] BAT_CTRL_RESET = 8'h00;
    localparam logic [7:0] BAT_CTRL_WMASK = 8'h0f;
    localparam logic [7:0] BAT_CFG_RESET = 8'h02;

    localparam int WAKE_SHORT_BIT = 7;
    localparam int WAKE_LATCH_BIT = 6;
    localparam int WAKE_BAT_BIT = 5;
    localparam int WAKE_PIN_BIT = 4;
    localparam int WAKE_ALARM_BIT = 3;
    localparam int WAKE_USB_BIT = 0;
    localparam int PWR_RET_LV_BIT = 6;
    localparam int PWR_SMALL_BIT = 5;
    localparam int PWR_MAIN_BIT = 4;
    localparam int STAT_BUSY_BIT = 7;
    localparam int STAT_LIVE_BIT = 4;

    localparam int CORE_CLK_MHZ = 125;
    localparam int HS_OSC_STARTUP_NS = 1000;
    localparam int HS_OSC_STARTUP_CYCLES = (HS_OSC_STARTUP_NS * CORE_CLK_MHZ + 999) / 1000;
    localparam int WAKE_SHORT_CYCLES = 520;
    localparam int WAKE_LONG_CYCLES = 3590;
    localparam int WAKE_CNT_W = 13;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic [3:0] serial;
        logic [3:0] timer;
        logic radioCtrl;
        logic usbCtrl;
        logic pulseWidth;
        logic serialPeriph;
        logic smallSram;
        logic mainSram;
    } scw_gate_s;

    typedef struct packed {
        logic batteryLow;
        logic pinEvent;
        logic clockAlarm;
        logic usbEvent;
    } scw_wake_ev_s;

    function automatic logic [SCW_ADDR_W-1:0] scwByteAddr(input logic [31:0] idx);
        return {idx[SCW_ADDR_W-3:0], 2'b00};
    endfunction

endpackage

/* scw_sync3.sv */
// Three-stage synchroniser for levels arriving from outside the core clock.
// A change is passed on once the second and third stages agree.
`timescale 1ns/1ps
module scw_sync3 #(
    parameter int W = 1
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;
    wire [W-1:0] agree = ~(stage2 ^ stage3);

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            dout <= '0;
        end
        else
        begin
            stage1 <= din;
            stage2 <= stage1;
            stage3 <= stage2;
            dout <= (agree & stage3) | (~agree & dout);
        end
    end
endmodule

/* scw_top.sv */
// Sleep clock gating, wake source selection and sram retention control.
// Assumes an AXI4-Lite master on the core clock and wake events from other domains.
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
module scw_top
    import scw_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [scw_pkg::SCW_ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [scw_pkg::SCW_ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic sleepActive,
    input wire scw_pkg::scw_wake_ev_s wakeEventIn,
    input wire logic [7:0] batStateIn,
    output scw_pkg::scw_gate_s clockGate,
    output scw_pkg::scw_wake_ev_s wakeSourceEn,
    output logic retentionLowVoltage,
    output logic wakeBusy,
    output logic wakeDone,
    output logic [15:0] powerPlan,
    output logic [15:0] auxTrim,
    output logic [7:0] batDetCtrl,
    output logic [7:0] batDetCfg
);
    import scw_pkg::*;

    // Bus byte address of each register: four times its index
    localparam logic [SCW_ADDR_W-1:0] A_GATE_LO = scwByteAddr(IDX_GATE_LO);
    localparam logic [SCW_ADDR_W-1:0] A_GATE_HI = scwByteAddr(IDX_GATE_HI);
    localparam logic [SCW_ADDR_W-1:0] A_WAKE_CFG = scwByteAddr(IDX_WAKE_CFG);
    localparam logic [SCW_ADDR_W-1:0] A_PWR_CTRL = scwByteAddr(IDX_PWR_CTRL);
    localparam logic [SCW_ADDR_W-1:0] A_WAKE_STAT = scwByteAddr(IDX_WAKE_STAT);
    localparam logic [SCW_ADDR_W-1:0] A_PWR_PLAN = scwByteAddr(IDX_PWR_PLAN);
    localparam logic [SCW_ADDR_W-1:0] A_AUX_TRIM = scwByteAddr(IDX_AUX_TRIM);
    localparam logic [SCW_ADDR_W-1:0] A_BAT_CTRL = scwByteAddr(IDX_BAT_CTRL);
    localparam logic [SCW_ADDR_W-1:0] A_BAT_CFG = scwByteAddr(IDX_BAT_CFG);
    localparam logic [SCW_ADDR_W-1:0] A_BAT_STATE = scwByteAddr(IDX_BAT_STATE);

    // Merge one byte lane of write data under strobe and writable mask
    function automatic logic [7:0] laneMerge(
        input logic [7:0] old,
        input logic [7:0] newVal,
        input logic strobe,
        input logic [7:0] mask
    );
        logic [7:0] sel;
        sel = strobe ? mask : 8'h00;
        return (old & ~sel) | (newVal & sel);
    endfunction

    // Register state
    logic [7:0] gateLo;
    logic [7:0] gateHi;
    logic [7:0] wakeCfg;
    logic [7:0] pwrCtrl;
    logic [7:0] batState;
    logic [3:0] wakeLatched;

    // Write channel holding
    logic awHeld;
    logic wHeld;
    logic [SCW_ADDR_W-1:0] wrAddr;
    logic [31:0] wrData;
    logic [3:0] wrStrb;

    // Synchronised inputs
    scw_wake_ev_s eventSync;
    logic [7:0] batStateSync;

    scw_sync3 #(
        .W(4)
    ) u_event_sync (
        .core_clk(core_clk),
        .rst(rst),
        .din(wakeEventIn),
        .dout(eventSync)
    );

    scw_sync3 #(
        .W(8)
    ) u_bat_sync (
        .core_clk(core_clk),
        .rst(rst),
        .din(batStateIn),
        .dout(batStateSync)
    );

    // Wake source qualification
    wire batWakeEn = wakeCfg[WAKE_BAT_BIT];
    wire pinWakeEn = wakeCfg[WAKE_PIN_BIT];
    wire alarmWakeEn = wakeCfg[WAKE_ALARM_BIT];
    wire usbWakeEn = wakeCfg[WAKE_USB_BIT];
    wire [3:0] sourceEnable = {batWakeEn, pinWakeEn, alarmWakeEn, usbWakeEn};
    wire latchMode = wakeCfg[WAKE_LATCH_BIT];
    wire [3:0] qualified = eventSync & sourceEnable;
    wire [3:0] latchSet = (latchMode && sleepActive) ? qualified : 4'h0;
    wire [3:0] wakeCause = latchMode ? (qualified | wakeLatched) : qualified;
    wire seqStart = sleepActive && (|wakeCause) && !wakeBusy;
    // Without latching, losing every enabled event cancels a count under way
    wire seqAbort = !latchMode && !(|qualified);

    scw_wake_seq u_wake_seq (
        .core_clk(core_clk),
        .rst(rst),
        .start(seqStart),
        .abort(seqAbort),
        .shortSel(wakeCfg[WAKE_SHORT_BIT]),
        .busy(wakeBusy),
        .done(wakeDone)
    );

    // Write decode
    wire doWrite = awHeld && wHeld && !bvalid;

    wire wrGateLo = (wrAddr == A_GATE_LO);
    wire wrGateHi = (wrAddr == A_GATE_HI);
    wire wrWakeCfg = (wrAddr == A_WAKE_CFG);
    wire wrPwrCtrl = (wrAddr == A_PWR_CTRL);
    wire wrWakeStat = (wrAddr == A_WAKE_STAT);
    wire wrPwrPlan = (wrAddr == A_PWR_PLAN);
    wire wrAuxTrim = (wrAddr == A_AUX_TRIM);
    wire wrBatCtrl = (wrAddr == A_BAT_CTRL);
    wire wrBatCfg = (wrAddr == A_BAT_CFG);
    wire wrMapped = wrGateLo || wrGateHi || wrWakeCfg || wrPwrCtrl || wrWakeStat || wrPwrPlan
                    || wrAuxTrim || wrBatCtrl || wrBatCfg || (wrAddr == A_BAT_STATE);

    // Word access at the low gate address reaches both gate bytes
    wire [7:0] nextGateLo = laneMerge(gateLo, wrData[7:0], wrStrb[0], 8'hff);
    wire [7:0] nextGateHiWord = laneMerge(gateHi, wrData[15:8], wrStrb[1], GATE_HI_WMASK);
    wire [7:0] nextGateHiByte = laneMerge(gateHi, wrData[7:0], wrStrb[0], GATE_HI_WMASK);
    wire [7:0] nextWakeCfg = laneMerge(wakeCfg, wrData[7:0], wrStrb[0], WAKE_CFG_WMASK);
    wire [7:0] nextPwrCtrl = laneMerge(pwrCtrl, wrData[7:0], wrStrb[0], PWR_CTRL_WMASK);
    wire [15:0] nextPwrPlan = {laneMerge(powerPlan[15:8], wrData[15:8], wrStrb[1], PWR_PLAN_WMASK[15:8]),
                               laneMerge(powerPlan[7:0], wrData[7:0], wrStrb[0], PWR_PLAN_WMASK[7:0])};
    wire [15:0] nextAuxTrim = {laneMerge(auxTrim[15:8], wrData[15:8], wrStrb[1], AUX_TRIM_WMASK[15:8]),
                               laneMerge(auxTrim[7:0], wrData[7:0], wrStrb[0], AUX_TRIM_WMASK[7:0])};
    wire [7:0] nextBatCtrl = laneMerge(batDetCtrl, wrData[7:0], wrStrb[0], BAT_CTRL_WMASK);
    wire [7:0] nextBatCfg = laneMerge(batDetCfg, wrData[7:0], wrStrb[0], 8'hff);
    wire [3:0] latchClear = (doWrite && wrWakeStat && wrStrb[0]) ? wrData[3:0] : 4'h0;
    wire [3:0] next_wakeLatched = latchSet | (wakeLatched & ~latchClear & ~{4{wakeDone}});

    // Read decode
    wire [7:0] wakeStat = {wakeBusy, 2'b00, |qualified, wakeLatched};
    wire rdMapped = (araddr == A_GATE_LO) || (araddr == A_GATE_HI) || (araddr == A_WAKE_CFG)
                    || (araddr == A_PWR_CTRL) || (araddr == A_WAKE_STAT) || (araddr == A_PWR_PLAN)
                    || (araddr == A_AUX_TRIM) || (araddr == A_BAT_CTRL) || (araddr == A_BAT_CFG)
                    || (araddr == A_BAT_STATE);
    logic [31:0] readValue;

    always_comb
    begin
        readValue = 32'h0000_0000;
        unique case (araddr)
            A_GATE_LO: readValue = {16'h0000, gateHi, gateLo};
            A_GATE_HI: readValue = {24'h00_0000, gateHi};
            A_WAKE_CFG: readValue = {24'h00_0000, wakeCfg};
            A_PWR_CTRL: readValue = {24'h00_0000, pwrCtrl & PWR_CTRL_RMASK};
            A_WAKE_STAT: readValue = {24'h00_0000, wakeStat};
            A_PWR_PLAN: readValue = {16'h0000, powerPlan};
            A_AUX_TRIM: readValue = {16'h0000, auxTrim};
            A_BAT_CTRL: readValue = {24'h00_0000, batDetCtrl};
            A_BAT_CFG: readValue = {24'h00_0000, batDetCfg};
            A_BAT_STATE: readValue = {24'h00_0000, batState};
            default: readValue = 32'h0000_0000;
        endcase
    end

    // Write address and data channels, taken in either order
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awready <= 1'b0;
            wready <= 1'b0;
            wrAddr <= '0;
            wrData <= 32'h0000_0000;
            wrStrb <= 4'h0;
        end
        else
        begin
            if (awvalid && awready)
            begin
                awHeld <= 1'b1;
                wrAddr <= awaddr;
            end
            else if (doWrite)
            begin
                awHeld <= 1'b0;
            end

            if (wvalid && wready)
            begin
                wHeld <= 1'b1;
                wrData <= wdata;
                wrStrb <= wstrb;
            end
            else if (doWrite)
            begin
                wHeld <= 1'b0;
            end

            // Each channel refuses from the cycle after a take while its beat is held and while a response waits
            awready <= !awHeld && !bvalid && !(awvalid && awready);
            wready <= !wHeld && !bvalid && !(wvalid && wready);
        end
    end

    // Write response and register update
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            gateLo <= GATE_LO_RESET;
            gateHi <= GATE_HI_RESET;
            wakeCfg <= WAKE_CFG_RESET;
            pwrCtrl <= PWR_CTRL_RESET;
            powerPlan <= PWR_PLAN_RESET;
            auxTrim <= AUX_TRIM_RESET;
            batDetCtrl <= BAT_CTRL_RESET;
            batDetCfg <= BAT_CFG_RESET;
        end
        else
        begin
            if (bvalid && bready)
            begin
                bvalid <= 1'b0;
            end
            else if (doWrite)
            begin
                bvalid <= 1'b1;
                bresp <= wrMapped ? RESP_OKAY : RESP_SLVERR;
            end

            if (doWrite && wrGateLo)
            begin
                gateLo <= nextGateLo;
                gateHi <= nextGateHiWord;
            end

            if (doWrite && wrGateHi)
            begin
                gateHi <= nextGateHiByte;
            end

            if (doWrite && wrWakeCfg)
            begin
                wakeCfg <= nextWakeCfg;
            end

            if (doWrite && wrPwrCtrl)
            begin
                pwrCtrl <= nextPwrCtrl;
            end

            if (doWrite && wrPwrPlan)
            begin
                powerPlan <= nextPwrPlan;
            end

            if (doWrite && wrAuxTrim)
            begin
                auxTrim <= nextAuxTrim;
            end

            if (doWrite && wrBatCtrl)
            begin
                batDetCtrl <= nextBatCtrl;
            end

            if (doWrite && wrBatCfg)
            begin
                batDetCfg <= nextBatCfg;
            end
        end
    end

    // Read channel
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= RESP_OKAY;
        end
        else
        begin
            // A new address waits until the previous read data is taken
            arready <= !rvalid && !(arvalid && arready);

            if (arvalid && arready)
            begin
                rvalid <= 1'b1;
                rdata <= readValue;
                rresp <= rdMapped ? RESP_OKAY : RESP_SLVERR;
            end
            else if (rvalid && rready)
            begin
                rvalid <= 1'b0;
            end
        end
    end

    // Latched wake events and sampled battery state; a new event beats a clear
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            wakeLatched <= 4'h0;
            batState <= 8'h00;
        end
        else
        begin
            wakeLatched <= next_wakeLatched;
            batState <= batStateSync;
        end
    end

    assign clockGate = '{serial: gateLo[7:4], timer: gateLo[3:0], radioCtrl: gateHi[7], usbCtrl: gateHi[4],
                         pulseWidth: gateHi[2], serialPeriph: gateHi[0], smallSram: pwrCtrl[PWR_SMALL_BIT],
                         mainSram: pwrCtrl[PWR_MAIN_BIT]};
    assign wakeSourceEn = sourceEnable;
    assign retentionLowVoltage = pwrCtrl[PWR_RET_LV_BIT];
endmodule

/* scw_top_checker.sv */
// Checker for the sleep clock and wake control block.
// Sees only top-level ports; bound into every scw_top instance.
`timescale 1ns/1ps
module scw_top_checker
    import scw_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic sleepActive,
    input wire scw_pkg::scw_gate_s clockGate,
    input wire scw_pkg::scw_wake_ev_s wakeSourceEn,
    input wire logic retentionLowVoltage,
    input wire logic wakeBusy,
    input wire logic wakeDone
);
    logic [12:0] busyCnt;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // Length of the current post-wake count
    always_ff @(posedge core_clk)
    begin
        busyCnt <= (rst || !wakeBusy) ? 13'h0000 : busyCnt + 13'h0001;
    end
    reset_values_a: assert property ($fell(rst) |-> clockGate == '0 && wakeSourceEn == 4'h8)
        else $error("outputs not at reset values");
    gate_by_write_a: assert property ($changed(clockGate) |-> !awready && !wready)
        else $error("clock gate changed outside a write");
    src_by_write_a: assert property ($changed(wakeSourceEn) || $changed(retentionLowVoltage) |-> !awready)
        else $error("wake enable or retention changed outside a write");
    bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
    rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped early");
    write_answer_a: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
        else $error("write response late");
    read_answer_a: assert property (arvalid && arready |=> rvalid)
        else $error("read data late");
    done_pulse_a: assert property (wakeDone |-> $past(wakeBusy) ##1 !wakeDone)
        else $error("done not a single pulse after busy");
    wake_delay_a: assert property (wakeDone |-> busyCnt inside {[13'h0283:13'h0288], [13'h0e80:13'h0e85]})
        else $error("post-wake delay length wrong");
    busy_bound_a: assert property (busyCnt <= 13'h0e85)
        else $error("post-wake delay overran");
    wake_asleep_a: assert property ($rose(wakeBusy) |-> $past(sleepActive))
        else $error("wake count started while awake");
    cover property (bvalid && bready);
    cover property (rvalid && rready);
    cover property (wakeDone);
endmodule
bind scw_top scw_top_checker i_scw_top_checker (.core_clk(core_clk), .rst(rst), .awvalid(awvalid),
    .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
    .sleepActive(sleepActive), .clockGate(clockGate), .wakeSourceEn(wakeSourceEn),
    .retentionLowVoltage(retentionLowVoltage), .wakeBusy(wakeBusy), .wakeDone(wakeDone));

/* scw_top_tb.sv */
// Self-checking bench for the sleep clock and wake control block.
// Drives AXI4-Lite and wake events itself; checker is bound separately.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin errTotal++; \
    $display("MISMATCH %s exp %0h got %0h", nm, exp, got); end end
module scw_top_tb
    import scw_pkg::*;
;
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
        logic [31:0] rd;
        logic [13:0] gate;
        logic [3:0] src;
        logic ret;
    } scw_row_s;
    scw_row_s rows [11] = '{
        '{12'h030, 32'h0000ffff, 4'h3, 32'h000095ff, 14'h3ffc, 4'h8, 1'b0},
        '{12'h034, 32'h0000006a, 4'h1, 32'h00000000, 14'h3fc0, 4'h8, 1'b0},
        '{12'h030, 32'h0000005a, 4'h1, 32'h0000005a, 14'h1680, 4'h8, 1'b0},
        '{12'h038, 32'h000000ff, 4'h1, 32'h000000f9, 14'h1680, 4'hf, 1'b0},
        '{12'h038, 32'h00000006, 4'h1, 32'h00000000, 14'h1680, 4'h0, 1'b0},
        '{12'h03c, 32'h000000ff, 4'h1, 32'h00000030, 14'h1683, 4'h0, 1'b1},
        '{12'h03c, 32'h00000040, 4'h1, 32'h00000000, 14'h1680, 4'h0, 1'b1},
        '{12'h038, 32'h00000001, 4'h1, 32'h00000001, 14'h1680, 4'h1, 1'b1},
        '{12'h034, 32'h00000010, 4'h1, 32'h00000010, 14'h1690, 4'h1, 1'b1},
        '{12'h030, 32'h00008000, 4'h2, 32'h0000805a, 14'h16a0, 4'h1, 1'b1},
        '{12'h090, 32'h000000ff, 4'h1, 32'h0000000f, 14'h16a0, 4'h1, 1'b1}};
    logic [7:0] wakeCfgs [4] = '{8'ha0, 8'h90, 8'h88, 8'h81};
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic sleepActive = 1'b0;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0] wstrb = 4'h0;
    logic [7:0] batStateIn = 8'h3c;
    scw_wake_ev_s wakeEventIn = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, retentionLowVoltage, wakeBusy, wakeDone;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, rd;
    logic [15:0] powerPlan, auxTrim;
    logic [7:0] batDetCtrl, batDetCfg;
    scw_wake_ev_s wakeSourceEn;
    scw_gate_s clockGate;
    int errTotal = 0;
    int checked = 0;
    scw_top i_scw_top (.core_clk(core_clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .sleepActive(sleepActive), .wakeEventIn(wakeEventIn),
        .batStateIn(batStateIn), .clockGate(clockGate), .wakeSourceEn(wakeSourceEn),
        .retentionLowVoltage(retentionLowVoltage), .wakeBusy(wakeBusy), .wakeDone(wakeDone),
        .powerPlan(powerPlan), .auxTrim(auxTrim), .batDetCtrl(batDetCtrl), .batDetCfg(batDetCfg));
    initial
    begin
        forever #4 core_clk = ~core_clk;
    end
    task automatic tallyAndFinish();
        $display("checked %0d mismatches %0d", checked, errTotal);
        if (errTotal == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic axWrite(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        logic aDone;
        logic wDone;
        @(posedge core_clk);
        aDone = 1'b0;
        wDone = 1'b0;
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        wvalid <= 1'b1;
        while (!(aDone && wDone))
        begin
            @(posedge core_clk);
            aDone = aDone || awready;
            wDone = wDone || wready;
            if (aDone)
                awvalid <= 1'b0;
            if (wDone)
                wvalid <= 1'b0;
        end
        // Late bready keeps the response standing for a cycle
        while (!bvalid) @(posedge core_clk);
        bready <= 1'b1;
        @(posedge core_clk);
        resp = bresp;
        bready <= 1'b0;
    endtask
    task automatic axRead(input logic [11:0] a);
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        @(posedge core_clk);
        while (!arready) @(posedge core_clk);
        arvalid <= 1'b0;
        while (!rvalid) @(posedge core_clk);
        rready <= 1'b1;
        @(posedge core_clk);
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask
    // Sleep, raise an event (optionally a short pulse) and time the wake count
    task automatic wakeRun(input logic [7:0] cfg, input logic [3:0] ev, input logic pulse, input logic expDone);
        int cnt;
        int expCyc;
        axWrite(12'h038, {24'h000000, cfg}, 4'h1);
        @(posedge core_clk);
        sleepActive <= 1'b1;
        wakeEventIn <= ev;
        cnt = 0;
        expCyc = (cfg[7] ? WAKE_SHORT_CYCLES : WAKE_LONG_CYCLES) + HS_OSC_STARTUP_CYCLES;
        for (int k = 0; k < 4000 && !wakeDone; k++)
        begin
            @(posedge core_clk);
            cnt += wakeBusy;
            if (pulse && k == 8)
                wakeEventIn <= 4'h0;
        end
        `CHK("wakeDone", expDone, wakeDone)
        if (expDone)
            `CHK("wakeDelay", 1'b1, (cnt >= expCyc - 2) && (cnt <= expCyc + 3))
        sleepActive <= 1'b0;
        wakeEventIn <= 4'h0;
        repeat (12) @(posedge core_clk);
    endtask
    initial
    begin
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        repeat (6) @(posedge core_clk);
        `CHK("gateReset", 14'h0000, clockGate)
        `CHK("srcReset", 4'h8, wakeSourceEn)
        `CHK("planReset", 16'h11df, powerPlan)
        `CHK("batCfgReset", 8'h02, batDetCfg)
        `CHK("trimReset", 16'h0022, auxTrim)
        `CHK("batCtrlReset", 8'h00, batDetCtrl)
        axRead(12'h038);
        `CHK("wakeCfgReset", 32'h00000020, rd)
        axRead(12'h030);
        `CHK("gateWordReset", 32'h00000000, rd)
        axRead(12'h098);
        `CHK("batState", 32'h0000003c, rd)
        foreach (rows[i])
        begin
            axWrite(rows[i].addr, rows[i].data, rows[i].strb);
            `CHK("bresp", RESP_OKAY, resp)
            axRead(rows[i].addr);
            `CHK("readBack", rows[i].rd, rd)
            `CHK("clockGate", rows[i].gate, clockGate)
            `CHK("wakeSourceEn", rows[i].src, wakeSourceEn)
            `CHK("retention", rows[i].ret, retentionLowVoltage)
        end
        axWrite(12'h0a0, 32'hffffffff, 4'hf);
        `CHK("unmappedBresp", RESP_SLVERR, resp)
        `CHK("gateKept", 14'h16a0, clockGate)
        `CHK("batCtrl", 8'h0f, batDetCtrl)
        axRead(12'h0a0);
        `CHK("unmappedRresp", RESP_SLVERR, resp)
        `CHK("unmappedData", 32'h00000000, rd)
        for (int j = 0; j < 4; j++)
            wakeRun(wakeCfgs[j], 4'h8 >> j, 1'b0, 1'b1);
        wakeRun(8'h10, 4'h4, 1'b0, 1'b1);
        wakeRun(8'h88, 4'h4, 1'b0, 1'b0);
        wakeRun(8'hc8, 4'h2, 1'b1, 1'b1);
        wakeRun(8'h88, 4'h2, 1'b1, 1'b0);
        tallyAndFinish();
    end
    initial
    begin
        repeat (40000) @(posedge core_clk);
        errTotal++;
        tallyAndFinish();
    end
endmodule

/* scw_wake_seq.sv */
// Post-wake delay sequencer: counts oscillator startup plus the selected delay.
// Assumes start and abort are on the core clock.
`timescale 1ns/1ps
module scw_wake_seq
    import scw_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic start,
    input wire logic abort,
    input wire logic shortSel,
    output logic busy,
    output logic done
);
    typedef enum logic [1:0] {SEQ_IDLE = 2'b00, SEQ_WAIT = 2'b01, SEQ_DONE = 2'b11} scw_seq_e;
    localparam logic [WAKE_CNT_W-1:0] SHORT_LOAD = WAKE_CNT_W'(HS_OSC_STARTUP_CYCLES + WAKE_SHORT_CYCLES - 1);
    localparam logic [WAKE_CNT_W-1:0] LONG_LOAD = WAKE_CNT_W'(HS_OSC_STARTUP_CYCLES + WAKE_LONG_CYCLES - 1);

    scw_seq_e state;
    logic [WAKE_CNT_W-1:0] count;
    wire [WAKE_CNT_W-1:0] loadValue = shortSel ? SHORT_LOAD : LONG_LOAD;
    wire countZero = (count == '0);

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            state <= SEQ_IDLE;
            count <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            unique case (state)
                SEQ_IDLE:
                begin
                    if (start)
                    begin
                        state <= SEQ_WAIT;
                        count <= loadValue;
                        busy <= 1'b1;
                    end
                end
                SEQ_WAIT:
                begin
                    if (abort)
                    begin
                        state <= SEQ_IDLE;
                        busy <= 1'b0;
                    end
                    else if (countZero)
                    begin
                        state <= SEQ_DONE;
                        busy <= 1'b0;
                        done <= 1'b1;
                    end
                    else
                    begin
                        count <= count - 1'b1;
                    end
                end
                SEQ_DONE:
                begin
                    state <= SEQ_IDLE;
                end
                default:
                begin
                    state <= SEQ_IDLE;
                    busy <= 1'b0;
                end
            endcase
        end
    end
endmodule
